// ==== design/pif_top.sv ====
// Peripheral interrupt request flags with mask, control and AHB-Lite slave.
// Assumes source events are synchronous to clk; single word transfers only.
//
// Notes on behaviour
// RQ1 - Oscillator failure pending flag sits at bit 7, one while pending.
// RQ2 - Nonvolatile write completion sets the pending flag at bit 4.
// RQ3 - Serial port bus collision sets the pending flag at bit 3.
// RQ4 - Comparators at bits 6,5,2,1; second capture/compare unit at bit 0.
// RQ5 - Software sets the peripheral enable before any flag interrupts the CPU.
// RQ6 - Flags set regardless of enables, reset to zero, software clears them.
`default_nettype none
module pif_top
  import pif_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire pif_sources_t sources,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic              irq
);

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  pif_aphase_t     aph_r;
  logic            take;
  logic [7:0]      mask_r;
  logic [1:0]      control_r;
  logic [7:0]      request;
  logic            wr_request;
  logic            wr_clear;
  logic [7:0]      clr_bits;
  logic [7:0]      set_bits;
  logic [31:0]     rdata_nxt;

  assign take = hsel && htrans[1] && hready;

  function automatic logic [31:0] read_mux(input logic [7:0] off,
                                           input logic [7:0] req,
                                           input logic [7:0] msk,
                                           input logic [1:0] ctl);
    case (off)
      OFF_REQUEST: read_mux = {24'h000000, req};
      OFF_CLEAR:   read_mux = {24'h000000, req};
      OFF_MASK:    read_mux = {24'h000000, msk};
      OFF_CONTROL: read_mux = {30'h00000000, ctl};
      default:     read_mux = 32'h00000000;
    endcase
  endfunction : read_mux

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aph_r <= '0;
    end else if (hready) begin
      aph_r.valid  <= take && haddr[31:8] == 24'h000000;
      aph_r.write  <= hwrite;
      aph_r.offset <= haddr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // Read data is captured at the address edge so there are no wait states
  assign rdata_nxt = read_mux(haddr[7:0], request, mask_r, control_r);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite && haddr[31:8] == 24'h000000) begin
      hrdata <= rdata_nxt;
    end else if (take) begin
      hrdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  // No wait states and never an error response
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  // One decode for every register write in its data phase
  function automatic logic wr_hit(input pif_aphase_t aph,
                                  input logic [7:0]  off);
    wr_hit = aph.valid && aph.write && aph.offset == off;
  endfunction : wr_hit

  assign wr_request = wr_hit(aph_r, OFF_REQUEST);
  assign wr_clear   = wr_hit(aph_r, OFF_CLEAR);
  assign clr_bits   = wr_clear ? hwdata[7:0] : 8'h00;
  assign set_bits   = sources; // RQ1 RQ2 RQ3 RQ4 RQ6

  pif_flag_bank #(
    .W         (FLAG_W),
    .RESET_VAL (REQUEST_RESET)
  ) u_flags (
    .clk     (clk),
    .reset_n (reset_n),
    .set     (set_bits),
    .wr_en   (wr_request),
    .wr_data (hwdata[7:0]),
    .clr     (clr_bits),
    .flags_r (request)
  );

  // ----------------------------------------------------------------
  // Mask and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mask_r <= MASK_RESET;
    end else if (wr_hit(aph_r, OFF_MASK)) begin
      mask_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_r <= CONTROL_RESET;
    end else if (wr_hit(aph_r, OFF_CONTROL)) begin
      control_r <= hwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Nothing reaches the CPU until both enables are set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(request & mask_r) && control_r[BIT_PERIPH_EN] // RQ5
             && control_r[BIT_GLOBAL_EN];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_osc_fail_set: assert property (@(posedge clk) disable iff (!reset_n) // RQ1
    sources.oscillator_failure_flag |=> request[BIT_OSC_FAIL])
    else $error("Oscillator failure flag not set");

  a_nv_done_set: assert property (@(posedge clk) disable iff (!reset_n) // RQ2
    sources.nonvolatile_write_done_flag |=> request[BIT_NV_DONE])
    else $error("Write completion flag not set");

  a_collision_set: assert property (@(posedge clk) disable iff (!reset_n) // RQ3
    sources.serial_bus_collision_flag |=> request[BIT_COLLISION] ##1
      (request[BIT_COLLISION] || $past(wr_request || wr_clear)))
    else $error("Bus collision flag not set or lost");

  a_comp_positions: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    (sources.comparator_two_flag || sources.comparator_one_flag
     || sources.comparator_four_flag || sources.comparator_three_flag
     || sources.capture_compare_two_flag)
    |=> (request[BIT_COMP_TWO] || !$past(sources.comparator_two_flag))
        && (request[BIT_COMP_ONE] || !$past(sources.comparator_one_flag))
        && (request[BIT_COMP_FOUR] || !$past(sources.comparator_four_flag))
        && (request[BIT_COMP_THREE] || !$past(sources.comparator_three_flag))
        && (request[BIT_CCP_TWO] || !$past(sources.capture_compare_two_flag)))
    else $error("Comparator or capture flag misplaced");

  a_reset_clear: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    $rose(reset_n) |-> request == REQUEST_RESET && mask_r == MASK_RESET
                       && control_r == CONTROL_RESET && !irq)
    else $error("Flags not zero after reset");

  a_irq_gating: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    irq |-> $past(control_r[BIT_PERIPH_EN]) && $past(control_r[BIT_GLOBAL_EN])
            && $past(|(request & mask_r)))
    else $error("Interrupt raised without enable");

  a_no_spurious: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    !wr_request |=> (request & ~$past(request) & ~$past(set_bits)) == 8'h00)
    else $error("Flag set without its source");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    !wr_request && !wr_clear |=> (request & $past(request)) == $past(request))
    else $error("Pending flag lost without a write");

  a_write_clear: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    wr_clear |=> (request & $past(clr_bits) & ~$past(set_bits)) == 8'h00)
    else $error("Write one to clear did not clear");

  a_write_store: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    wr_request |=> request == ($past(hwdata[7:0]) | $past(set_bits)))
    else $error("Request write not stored");

  a_set_wins: assert property (@(posedge clk) disable iff (!reset_n) // RQ6
    (|set_bits) |=> (request & $past(set_bits)) == $past(set_bits))
    else $error("Source event lost against a write");

  a_irq_raise: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    (|(request & mask_r)) && control_r[BIT_PERIPH_EN] && control_r[BIT_GLOBAL_EN]
    |=> irq)
    else $error("Enabled pending flag gave no interrupt");

  a_irq_clear_low: assert property (@(posedge clk) disable iff (!reset_n) // RQ5
    !control_r[BIT_PERIPH_EN] |=> !irq)
    else $error("Interrupt raised with peripheral enable off");

endmodule : pif_top
`default_nettype wire

// ==== design/pif_pkg.sv ====
// Package for the peripheral interrupt request flag block.
// Assumes a single 100 MHz clock and an AHB-Lite register bus.
`default_nettype none
package pif_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_REQUEST = 8'h00;
  localparam logic [7:0] OFF_MASK    = 8'h04;
  localparam logic [7:0] OFF_CONTROL = 8'h08;
  localparam logic [7:0] OFF_CLEAR   = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         FLAG_W          = 8;
  localparam int         BIT_OSC_FAIL    = 7;
  localparam int         BIT_COMP_TWO    = 6;
  localparam int         BIT_COMP_ONE    = 5;
  localparam int         BIT_NV_DONE     = 4;
  localparam int         BIT_COLLISION   = 3;
  localparam int         BIT_COMP_FOUR   = 2;
  localparam int         BIT_COMP_THREE  = 1;
  localparam int         BIT_CCP_TWO     = 0;
  localparam int         BIT_PERIPH_EN   = 0;
  localparam int         BIT_GLOBAL_EN   = 1;
  localparam logic [7:0] REQUEST_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [1:0] CONTROL_RESET   = 2'h0;

  // Event sources, most significant field is bit 7 of the request register
  typedef struct packed {
    logic oscillator_failure_flag;
    logic comparator_two_flag;
    logic comparator_one_flag;
    logic nonvolatile_write_done_flag;
    logic serial_bus_collision_flag;
    logic comparator_four_flag;
    logic comparator_three_flag;
    logic capture_compare_two_flag;
  } pif_sources_t;

  // Latched address phase of an AHB-Lite transfer
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] offset;
  } pif_aphase_t;

endpackage : pif_pkg
`default_nettype wire

// ==== design/pif_flag_bank.sv ====
// Bank of sticky flags with write, write-one-to-clear and hardware set.
// Assumes all inputs synchronous to clk; set always wins over clearing.
`default_nettype none
module pif_flag_bank #(
  parameter int         W         = 8,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] set,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags_r
);

  logic [W-1:0] flags_nxt;

  always_comb begin
    flags_nxt = wr_en ? wr_data : flags_r;
    flags_nxt = (flags_nxt & ~clr) | set;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_r <= RESET_VAL;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule : pif_flag_bank
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the peripheral interrupt flag block.
// Assumes the block is the only AHB-Lite slave, so its hreadyout is hready.
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb_top
  import pif_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         reset_n = 1'b0;
  logic         hsel = 1'b0;
  logic         hwrite = 1'b0;
  logic [1:0]   htrans = 2'h0;
  logic [31:0]  haddr = 32'h0;
  logic [31:0]  hwdata = 32'h0;
  pif_sources_t sources = '0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic         irq;
  logic [31:0]  rd;
  logic [7:0]   m_req = 8'h00;
  logic [7:0]   m_msk = 8'h00;
  logic [1:0]   m_ctl = 2'h0;
  int           error_cnt = 0;
  int           n_compared = 0;

  always #5 clk = ~clk;

  pif_top dut (.clk(clk), .reset_n(reset_n), .sources(sources), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

  // ----------------------------------------------------------------
  // Bus and event tasks
  // ----------------------------------------------------------------
  task print_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task wait_ready;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        error_cnt++;
        print_verdict();
      end
      @(posedge clk);
    end
  endtask : wait_ready

  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsel   <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask : xfer

  task wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
    case (a)
      OFF_REQUEST: m_req = d;
      OFF_MASK:    m_msk = d;
      OFF_CONTROL: m_ctl = d[1:0];
      OFF_CLEAR:   m_req = m_req & ~d;
      default: ;
    endcase
  endtask : wr

  task rchk(input logic [31:0] a);
    logic [31:0] e;
    case (a)
      OFF_REQUEST, OFF_CLEAR: e = {24'h0, m_req};
      OFF_MASK:    e = {24'h0, m_msk};
      OFF_CONTROL: e = {30'h0, m_ctl};
      default:     e = 32'h0;
    endcase
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : rchk

  task fire(input pif_sources_t s);
    sources <= s;
    @(posedge clk);
    sources <= '0;
    m_req = m_req | s;
    @(posedge clk);
  endtask : fire

  task ichk;
    repeat (2) @(posedge clk);
    `CHK(irq, ((|(m_req & m_msk)) && m_ctl == 2'h3))
  endtask : ichk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pif_sources_t s;
    logic [31:0]  offs [5];
    offs = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h100};
    void'($urandom(32'h7e55));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    foreach (offs[j]) rchk(offs[j]);
    wr(32'h104, 8'hff);
    rchk(OFF_MASK);
    s = '0;
    s.oscillator_failure_flag = 1'b1;
    fire(s);
    rchk(OFF_REQUEST);
    `CHK(rd, 32'h80)
    s = '0;
    s.nonvolatile_write_done_flag = 1'b1;
    fire(s);
    s = '0;
    s.serial_bus_collision_flag = 1'b1;
    fire(s);
    rchk(OFF_REQUEST);
    `CHK(rd, 32'h98)
    wr(OFF_REQUEST, 8'h00);
    for (int i = 0; i < 8; i++) begin
      fire(pif_sources_t'(8'h1 << i));
      rchk(OFF_REQUEST);
      wr(OFF_REQUEST, 8'h00);
    end
    s = '0;
    s.comparator_two_flag      = 1'b1;
    s.comparator_one_flag      = 1'b1;
    s.comparator_four_flag     = 1'b1;
    s.comparator_three_flag    = 1'b1;
    s.capture_compare_two_flag = 1'b1;
    fire(s);
    rchk(OFF_REQUEST);
    `CHK(rd, 32'h67)
    wr(OFF_REQUEST, 8'h00);
    fire(pif_sources_t'(8'h24));
    ichk();
    wr(OFF_MASK, 8'h04);
    ichk();
    wr(OFF_CONTROL, 8'h01);
    ichk();
    wr(OFF_CONTROL, 8'h03);
    ichk();
    wr(OFF_CLEAR, 8'h04);
    ichk();
    rchk(OFF_CLEAR);
    repeat (60) begin
      case ($urandom % 4)
        0: fire(pif_sources_t'(8'($urandom)));
        1: wr({28'h0, 2'($urandom), 2'h0}, 8'($urandom));
        2: rchk(offs[$urandom % 5]);
        default: ichk();
      endcase
    end
    fire(pif_sources_t'(8'hff));
    wr(OFF_MASK, 8'hff);
    wr(OFF_CONTROL, 8'h03);
    ichk();
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    m_req = 8'h00;
    m_msk = 8'h00;
    m_ctl = 2'h0;
    foreach (offs[j]) rchk(offs[j]);
    ichk();
    print_verdict();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
